// ---- spb_pkg.sv ----
// Purpose: Shared constants for the byte-wide serial peripheral block
// Assumes: 32-bit AXI4-Lite register bus, 250 MHz bus clock
// Notes:   Offsets are also used by the testbench; bit positions by the main module only
package spb_pkg;

   // Register byte offsets
   localparam logic [3:0] SPB_OFS_CTRL = 4'h0;   // control_reg
   localparam logic [3:0] SPB_OFS_STAT = 4'h4;   // status_control_reg
   localparam logic [3:0] SPB_OFS_DATA = 4'h8;   // data_register

   // control_reg field positions
   localparam int SPB_C_TXIE = 0;                // tx_irq_enable
   localparam int SPB_C_ON   = 1;                // module_on
   localparam int SPB_C_OD   = 2;                // open_drain_mode
   localparam int SPB_C_CPHA = 3;                // clock phase
   localparam int SPB_C_CPOL = 4;                // clock polarity
   localparam int SPB_C_MSTR = 5;                // master_select
   localparam int SPB_C_RXIE = 7;                // rx_irq_enable

   // status_control_reg field positions
   localparam int SPB_S_BAUD = 0;                // baud_select_lo, _hi above
   localparam int SPB_S_FDEN = 2;                // fault_detect_enable
   localparam int SPB_S_TXE  = 3;                // tx_empty_flag
   localparam int SPB_S_MODE_FAULT_FLAG = 4;                // mode_fault_flag
   localparam int SPB_S_OVR  = 5;                // overrun_flag
   localparam int SPB_S_ERIE = 6;                // error_irq_enable
   localparam int SPB_S_RXF  = 7;                // rx_full_flag

   // Reset values of the control bits that do not reset to zero
   localparam logic SPB_RST_MSTR = 1'b1;
   localparam logic SPB_RST_CPHA = 1'b1;

   // Serial clock half periods minus one, in bus clocks, per baud code
   localparam logic [4:0] SPB_HP_M1_0 = 5'h01;
   localparam logic [4:0] SPB_HP_M1_1 = 5'h03;
   localparam logic [4:0] SPB_HP_M1_2 = 5'h07;
   localparam logic [4:0] SPB_HP_M1_3 = 5'h0f;

   // Edge numbers within a byte (16 edges per byte)
   localparam logic [3:0] SPB_EDGE_BIT1 = 4'hc;  // 7th capture, CPHA 0
   localparam logic [3:0] SPB_EDGE_LAST = 4'hf;  // final edge of byte

   // AXI responses
   localparam logic [1:0] SPB_RESP_OKAY   = 2'h0;
   localparam logic [1:0] SPB_RESP_SLVERR = 2'h2;

   // Transfer engine states
   typedef enum logic {SPB_IDLE, SPB_XFER} spb_state_e;

endpackage : spb_pkg

// ---- spb_sync.sv ----
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to aclk
// Notes:   First stage is read by the second stage only
`timescale 1ns/1ps
module spb_sync #(
   parameter int W = 1
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;   // Metastability catcher

   // Two stages, both reset to zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : spb_sync

// ---- spb_core.sv ----
// Purpose: Serial peripheral block: registers, byte engine, flags, pins
// Assumes: Link clock and selects are sampled by aclk through spb_sync
// Notes:   Slave clock must be well below a quarter of aclk
`timescale 1ns/1ps

// Overview of operation
// - Tx request needs empty, enable, module on
// - Rx request on full and enable
// - Error enable lets overrun, fault share request
// - Fault flag never sets without detect enable
// - Status then data read clears rx_full
// - Only data write clears tx_empty
// - Received byte transfer sets rx_full
// - Buffer to shifter move sets tx_empty
// - System reset restores every bit and flag
// - Module off: abort, clear shifter, release pins
// - Control bits and flags survive module off, except tx_empty, which is set
// - Master fault or software clears module_on
// - Wait mode: runs, no access, wakes
// - Stop halts engine, keeps registers
// - Break without clear enable protects flags
// - Break with clear enable: clears stick
// - Protected break: data write ignored
// - Open drain mode on driven lines
// - Slave drives MISO only when selected
// - Enabled block owns pin directions
// - Master clocks, eight cycles per byte
// - Unread byte at bit 1 sets overrun
// - Status then data read clears overrun
// - Fault on select level against mode
// - Status read, control write clears fault
module spb_core (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite slave
   input  wire logic [3:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [3:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // Serial pins
   input  wire logic        sck_i,
   output logic             sck_o,
   output logic             sck_oe,
   input  wire logic        mosi_i,
   output logic             mosi_o,
   output logic             mosi_oe,
   input  wire logic        miso_i,
   output logic             miso_o,
   output logic             miso_oe,
   input  wire logic        ss_n_i,
   output logic             pins_owned,
   // System state
   input  wire logic        break_active,
   input  wire logic        break_clear_enable,
   input  wire logic        wait_mode,
   input  wire logic        stop_mode,
   // Requests
   output logic             tx_irq,
   output logic             rx_err_irq,
   output logic             wake_req
);
   import spb_pkg::*;

   // Synchronised pins
   logic [3:0] in_s;
   logic       sck_s, mosi_s, miso_s, ssn_s;
   logic       sck_d_r, ssn_d_r;        // Previous synced levels

   // Control and status bits
   logic       rx_ie_r, mstr_r, cpol_r, cpha_r, od_r, on_r, tx_ie_r;
   logic       err_ie_r, fden_r;
   logic [1:0] baud_r;
   logic       rxf_r, ovr_r, mode_fault_flag_r, txe_r;
   logic       arm_rx_r, arm_ovr_r, arm_mf_r;   // First clear step seen

   // Data path
   logic [7:0] txbuf_r, rxbuf_r, shreg_r;
   logic       out_bit_r;               // Bit on the data line
   spb_state_e state_r;
   logic [3:0] edge_cnt_r;              // Edge counter, 16 edges/byte
   logic [4:0] div_r;                   // Master half period divider
   logic [4:0] hp_m1;

   // Bus holding registers
   logic        aw_have_r, w_have_r;
   logic [3:0]  awaddr_r;
   logic [7:0]  wbyte_r;
   logic        wlane_r;

   // Decoded events
   logic frozen, xfer, tick, edge_ev, sample_ev, shift_ev, last_ev;
   logic strobe1, start, load_ev, abort, din, rx_take;
   logic mf_master, mf_slave, mf_cond;
   logic wr_go, rd_go, wr_ok, rd_ok;
   logic wr_ctrl, wr_stat, wr_data, rd_stat, rd_data;
   logic [7:0] sh_nxt, rx_word, ctrl_rd, stat_rd, rd_byte;

   spb_sync #(.W(4)) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       ({sck_i, mosi_i, miso_i, ss_n_i}),
      .q       (in_s)
   );
   assign {sck_s, mosi_s, miso_s, ssn_s} = in_s;

   // Edge history from the second stage only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sck_d_r <= 1'b0;
         ssn_d_r <= 1'b1;
      end else begin
         sck_d_r <= sck_s;
         ssn_d_r <= ssn_s;
      end
   end

   // Baud code to half period
   always_comb begin
      case (baud_r)
         2'h0:    hp_m1 = SPB_HP_M1_0;
         2'h1:    hp_m1 = SPB_HP_M1_1;
         2'h2:    hp_m1 = SPB_HP_M1_2;
         default: hp_m1 = SPB_HP_M1_3;
      endcase
   end

   // Engine event decode
   always_comb begin
      frozen = break_active & ~break_clear_enable;
      xfer   = (state_r == SPB_XFER);
      tick   = xfer & mstr_r & (div_r == 5'h00) & ~stop_mode;
      edge_ev = mstr_r ? tick
                       : xfer & ~ssn_s & (sck_s ^ sck_d_r) & ~stop_mode;
      sample_ev = edge_ev & (edge_cnt_r[0] == cpha_r);
      shift_ev  = edge_ev & ~sample_ev;
      last_ev   = edge_ev & (edge_cnt_r == SPB_EDGE_LAST);
      strobe1   = sample_ev & (edge_cnt_r == (SPB_EDGE_BIT1 | {3'h0, cpha_r}));
      din       = mstr_r ? miso_s : mosi_s;
      sh_nxt    = {shreg_r[6:0], din};
      rx_word   = cpha_r ? sh_nxt : shreg_r;
      // Slave with CPHA 0 needs a fresh select fall per byte
      start = ~xfer & on_r & ~stop_mode &
              (mstr_r ? ~txe_r : ~ssn_s & (cpha_r | ssn_d_r));
      load_ev = start & ~txe_r;
      mf_master = on_r & mstr_r & fden_r & ~ssn_s;
      mf_slave  = on_r & ~mstr_r & fden_r & ssn_s & xfer &
                  (~cpha_r | (edge_cnt_r != 4'h0));
      mf_cond   = mf_master | mf_slave;
      // Slave ignores clocks once deselected
      abort   = ~on_r | mf_master | (~mstr_r & ssn_s);
      rx_take = last_ev & ~ovr_r;
   end

   // Off or fault aborts, counter cleared
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r    <= SPB_IDLE;
         edge_cnt_r <= 4'h0;
      end else if (abort) begin
         state_r    <= SPB_IDLE;
         edge_cnt_r <= 4'h0;
      end else begin
         case (state_r)
            SPB_IDLE: begin
               edge_cnt_r <= 4'h0;
               if (start) begin
                  state_r <= SPB_XFER;
               end
            end
            SPB_XFER: begin
               if (edge_ev) begin
                  edge_cnt_r <= edge_cnt_r + 4'h1;
                  if (last_ev) begin
                     state_r <= SPB_IDLE;
                  end
               end
            end
            default: begin
               state_r <= SPB_IDLE;
            end
         endcase
      end
   end

   // Master half period divider
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_r <= 5'h00;
      end else if (stop_mode) begin
         div_r <= div_r;
      end else if (!xfer || tick) begin
         div_r <= hp_m1;
      end else begin
         div_r <= div_r - 5'h01;
      end
   end

   // Shift register and outgoing bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shreg_r   <= 8'h00;
         out_bit_r <= 1'b0;
      end else if (!on_r) begin
         shreg_r   <= 8'h00;
         out_bit_r <= 1'b0;
      end else if (load_ev) begin
         shreg_r   <= txbuf_r;
         out_bit_r <= txbuf_r[7];
      end else if (start) begin
         // Nothing queued: shifter content, the last received byte, goes out
         out_bit_r <= shreg_r[7];
      end else if (sample_ev) begin
         shreg_r   <= sh_nxt;
      end else if (shift_ev) begin
         out_bit_r <= shreg_r[7];
      end
   end

   // Bus access decode; wait mode blocks the register file
   always_comb begin
      wr_go   = aw_have_r & w_have_r & ~bvalid;
      rd_go   = arvalid & arready;
      wr_ok   = wr_go & ~wait_mode & wlane_r;
      rd_ok   = rd_go & ~wait_mode;
      wr_ctrl = wr_ok & (awaddr_r == SPB_OFS_CTRL);
      wr_stat = wr_ok & (awaddr_r == SPB_OFS_STAT);
      wr_data = wr_ok & (awaddr_r == SPB_OFS_DATA) & ~frozen & on_r;
      rd_stat = rd_ok & (araddr == SPB_OFS_STAT) & ~frozen;
      rd_data = rd_ok & (araddr == SPB_OFS_DATA) & ~frozen;
   end

   // Control bits; untouched by module off
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_ie_r  <= 1'b0;
         mstr_r   <= SPB_RST_MSTR;
         cpol_r   <= 1'b0;
         cpha_r   <= SPB_RST_CPHA;
         od_r     <= 1'b0;
         on_r     <= 1'b0;
         tx_ie_r  <= 1'b0;
         err_ie_r <= 1'b0;
         fden_r   <= 1'b0;
         baud_r   <= 2'h0;
      end else begin
         // Only reset, software or a master fault (module_on) changes these
         if (wr_ctrl) begin
            rx_ie_r <= wbyte_r[SPB_C_RXIE];
            mstr_r  <= wbyte_r[SPB_C_MSTR];
            cpol_r  <= wbyte_r[SPB_C_CPOL];
            cpha_r  <= wbyte_r[SPB_C_CPHA];
            od_r    <= wbyte_r[SPB_C_OD];
            on_r    <= wbyte_r[SPB_C_ON];
            tx_ie_r <= wbyte_r[SPB_C_TXIE];
         end
         // Master fault disables, wins over write
         if (mf_master) begin
            on_r <= 1'b0;
         end
         if (wr_stat) begin
            err_ie_r <= wbyte_r[SPB_S_ERIE];
            fden_r   <= wbyte_r[SPB_S_FDEN];
            baud_r   <= wbyte_r[SPB_S_BAUD +: 2];
         end
      end
   end

   // Transmit buffer and received byte
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         txbuf_r <= 8'h00;
         rxbuf_r <= 8'h00;
      end else begin
         if (wr_data) begin
            txbuf_r <= wbyte_r;
         end
         if (rx_take) begin
            rxbuf_r <= rx_word;
         end
      end
   end

   // First clear step; held across break, so it completes later
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arm_rx_r  <= 1'b0;
         arm_ovr_r <= 1'b0;
         arm_mf_r  <= 1'b0;
      end else begin
         if (rd_stat) begin
            arm_rx_r  <= rxf_r;
            arm_ovr_r <= ovr_r;
            arm_mf_r  <= mode_fault_flag_r;
         end else begin
            if (rd_data) begin
               arm_rx_r  <= 1'b0;
               arm_ovr_r <= 1'b0;
            end
            if (wr_ctrl && !frozen) begin
               arm_mf_r <= 1'b0;
            end
         end
      end
   end

   // Status flags; a set in the clearing cycle wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rxf_r  <= 1'b0;
         ovr_r  <= 1'b0;
         mode_fault_flag_r <= 1'b0;
         txe_r  <= 1'b1;
      end else begin
         // Cleared by status then data read
         rxf_r  <= rx_take | (rxf_r & ~(rd_data & arm_rx_r));
         // Cleared by status then data read
         ovr_r  <= (strobe1 & rxf_r) | (ovr_r & ~(rd_data & arm_ovr_r));
         // Clears only with no fault present
         mode_fault_flag_r <= mf_cond |
                   (mode_fault_flag_r & ~(wr_ctrl & arm_mf_r & ~frozen & ~mf_cond));
         // Set on shifter load; held set while off
         // Only a data write clears it
         txe_r  <= load_ev | ~on_r | (txe_r & ~wr_data);
      end
   end

   // Interrupt requests and wake request
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_irq     <= 1'b0;
         rx_err_irq <= 1'b0;
         wake_req   <= 1'b0;
      end else begin
         tx_irq     <= txe_r & tx_ie_r & on_r;
         rx_err_irq <= (rxf_r & rx_ie_r) | (err_ie_r & (ovr_r | mode_fault_flag_r));
         wake_req   <= wait_mode & ((txe_r & tx_ie_r & on_r) |
                       (rxf_r & rx_ie_r) | (err_ie_r & (ovr_r | mode_fault_flag_r)));
      end
   end

   // Pin drivers; off hands pins to the port
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sck_o      <= 1'b0;
         sck_oe     <= 1'b0;
         mosi_o     <= 1'b0;
         mosi_oe    <= 1'b0;
         miso_o     <= 1'b0;
         miso_oe    <= 1'b0;
         pins_owned <= 1'b0;
      end else begin
         pins_owned <= on_r;
         sck_o   <= ~od_r & (cpol_r ^ (xfer & edge_cnt_r[0]));
         mosi_o  <= ~od_r & out_bit_r;
         miso_o  <= ~od_r & out_bit_r;
         sck_oe  <= on_r & mstr_r & (~od_r | ~(cpol_r ^ (xfer & edge_cnt_r[0])));
         mosi_oe <= on_r & mstr_r & (~od_r | ~out_bit_r);
         miso_oe <= on_r & ~mstr_r & ~ssn_s & (~od_r | ~out_bit_r);
      end
   end

   // Register read mux
   always_comb begin
      ctrl_rd = 8'h00;
      ctrl_rd[SPB_C_RXIE] = rx_ie_r;
      ctrl_rd[SPB_C_MSTR] = mstr_r;
      ctrl_rd[SPB_C_CPOL] = cpol_r;
      ctrl_rd[SPB_C_CPHA] = cpha_r;
      ctrl_rd[SPB_C_OD]   = od_r;
      ctrl_rd[SPB_C_ON]   = on_r;
      ctrl_rd[SPB_C_TXIE] = tx_ie_r;
      stat_rd = 8'h00;
      stat_rd[SPB_S_RXF]  = rxf_r;
      stat_rd[SPB_S_ERIE] = err_ie_r;
      stat_rd[SPB_S_OVR]  = ovr_r;
      stat_rd[SPB_S_MODE_FAULT_FLAG] = mode_fault_flag_r;
      stat_rd[SPB_S_TXE]  = txe_r;
      stat_rd[SPB_S_FDEN] = fden_r;
      stat_rd[SPB_S_BAUD +: 2] = baud_r;
      case (araddr)
         SPB_OFS_CTRL: rd_byte = ctrl_rd;
         SPB_OFS_STAT: rd_byte = stat_rd;
         SPB_OFS_DATA: rd_byte = rxbuf_r;
         default:      rd_byte = 8'h00;
      endcase
   end

   // Write address and data capture, either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         awaddr_r  <= 4'h0;
         wbyte_r   <= 8'h00;
         wlane_r   <= 1'b0;
         awready   <= 1'b0;
         wready    <= 1'b0;
      end else if (bvalid && bready) begin
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         awready   <= 1'b1;
         wready    <= 1'b1;
      end else begin
         if (awvalid && awready) begin
            aw_have_r <= 1'b1;
            awaddr_r  <= awaddr;
            awready   <= 1'b0;
         end else if (!aw_have_r && !bvalid) begin
            awready <= 1'b1;
         end
         if (wvalid && wready) begin
            w_have_r <= 1'b1;
            wbyte_r  <= wdata[7:0];
            wlane_r  <= wstrb[0];
            wready   <= 1'b0;
         end else if (!w_have_r && !bvalid) begin
            wready <= 1'b1;
         end
      end
   end

   // Write response; unmapped or wait mode answers SLVERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= SPB_RESP_OKAY;
      end else if (wr_go) begin
         bvalid <= 1'b1;
         bresp  <= (wait_mode || awaddr_r > SPB_OFS_DATA || awaddr_r[1:0] != 2'h0)
                   ? SPB_RESP_SLVERR : SPB_RESP_OKAY;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // Read channel; one outstanding read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= SPB_RESP_OKAY;
      end else if (rd_go) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= {24'h00_0000, wait_mode ? 8'h00 : rd_byte};
         rresp   <= (wait_mode || araddr > SPB_OFS_DATA || araddr[1:0] != 2'h0)
                    ? SPB_RESP_SLVERR : SPB_RESP_OKAY;
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end else if (!rvalid) begin
         arready <= 1'b1;
      end
   end

endmodule : spb_core

// ---- spb_chk.sv ----
// Purpose: Port checker for spb_core
// Assumes: One aclk domain, sync low reset
// Notes:   Bound to every spb_core
`timescale 1ns/1ps
module spb_chk (
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic [1:0] rresp,
   input wire logic       rvalid,
   input wire logic       bvalid,
   input wire logic       sck_o,
   input wire logic       sck_oe,
   input wire logic       mosi_o,
   input wire logic       mosi_oe,
   input wire logic       miso_oe,
   input wire logic       ss_n_i,
   input wire logic       pins_owned,
   input wire logic       wait_mode,
   input wire logic       stop_mode,
   input wire logic       tx_irq,
   input wire logic       rx_err_irq,
   input wire logic       wake_req
);
   import spb_pkg::*;
   // Reset masks every check
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   reset_clear_a: assert property ($rose(aresetn) |-> !(pins_owned | tx_irq | rx_err_irq | bvalid | rvalid))
      else $error("output set after reset");
   tx_on_a: assert property (tx_irq |-> pins_owned)
      else $error("tx request while off");
   wake_wait_a: assert property (wake_req |-> $past(wait_mode))
      else $error("wake outside wait");
   wake_req_a: assert property (wait_mode ##1 (tx_irq | rx_err_irq) |-> wake_req)
      else $error("request did not wake");
   // Two cycles of slack for the pin register
   stop_hold_a: assert property (stop_mode [*3] |-> $stable(sck_o) && $stable(mosi_o))
      else $error("pins moved in stop");
   pins_free_a: assert property (!pins_owned [*2] |-> !(sck_oe | mosi_oe | miso_oe))
      else $error("pin driven while off");
   // Select passes a synchroniser first
   miso_quiet_a: assert property (ss_n_i [*6] |-> !miso_oe)
      else $error("data out while unselected");
   wait_err_a: assert property ($rose(rvalid) && $past(wait_mode) |-> rresp == SPB_RESP_SLVERR)
      else $error("read served in wait");
   rx_irq_c: cover property ($rose(rx_err_irq));
   pins_off_c: cover property ($fell(pins_owned));
   wake_c: cover property (wake_req);
endmodule : spb_chk

bind spb_core spb_chk i_chk (
   .aclk, .aresetn, .rresp, .rvalid, .bvalid, .sck_o, .sck_oe, .mosi_o, .mosi_oe, .miso_oe,
   .ss_n_i, .pins_owned, .wait_mode, .stop_mode, .tx_irq, .rx_err_irq, .wake_req
);

// ---- spb_slave_mdl.sv ----
// Purpose: Far-side serial slave
// Assumes: Clock idles low, launch on rise
// Notes:   Each byte sent is one above the last
`timescale 1ns/1ps
module spb_slave_mdl #(
   parameter logic [7:0] TX_BYTE = 8'h3c
) (
   input  wire logic  sck,
   input  wire logic  mosi,
   input  wire logic  sel_n,
   output logic       miso,
   output logic [7:0] rx_byte,
   output int         n_bytes
);
   logic [7:0] sh_r  = TX_BYTE; // Outgoing byte
   logic [2:0] cnt_r = 3'h0;    // Bits done
   logic       bit_r = 1'h0;    // Bit on line
   initial rx_byte = 8'h0;
   initial n_bytes = 0;
   always @(posedge sck) begin
      if (!sel_n) begin
         bit_r <= sh_r[7];
      end
   end
   // Capture on trailing edge, eight a byte
   always @(negedge sck) begin
      if (!sel_n) begin
         sh_r    <= (cnt_r == 3'h7) ? TX_BYTE + 8'(n_bytes + 1) : {sh_r[6:0], 1'h0};
         rx_byte <= {rx_byte[6:0], mosi};
         cnt_r   <= cnt_r + 3'h1;
         n_bytes <= n_bytes + int'(cnt_r == 3'h7);
      end
   end
   // Deselected: line carries the complement of the last bit
   assign miso = sel_n ? ~bit_r : bit_r;
endmodule : spb_slave_mdl

// ---- tb.sv ----
// Purpose: Self-checking bench for spb_core
// Assumes: Far side is one slave model
// Notes:   Slowest baud keeps sync margins wide
`timescale 1ns/1ps
module tb;
   import spb_pkg::*;
   logic        aclk = 1'h0, aresetn = 1'h0;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic        ss_n = 1'h1, brk = 1'h0, wt = 1'h0, stp = 1'h0, bce = 1'h0;
   logic        awready, wready, bvalid, arready, rvalid, sck_o, sck_oe, mosi_o, mosi_oe;
   logic        miso_o, miso_oe, pins_owned, tx_irq, rx_err_irq, wake_req;
   logic [1:0]  bresp, rresp, rs;
   logic [7:0]  q, s_rx;
   int          s_n, failures = 0, n_checks = 0;
   wire         sck_w, mosi_w, miso_w, s_miso;
   // Released clock and MOSI go to their pulls; MISO goes to the slave
   assign sck_w  = sck_oe ? sck_o : 1'h0;
   assign mosi_w = mosi_oe ? mosi_o : 1'h1;
   assign miso_w = miso_oe ? miso_o : s_miso;
   always #2 aclk = ~aclk;
   spb_core i_dut (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb (4'hf), .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .sck_i (sck_w), .sck_o, .sck_oe, .mosi_i (mosi_w), .mosi_o, .mosi_oe, .miso_i (miso_w),
      .miso_o, .miso_oe, .ss_n_i (ss_n), .pins_owned, .break_active (brk), .break_clear_enable (bce),
      .wait_mode (wt), .stop_mode (stp), .tx_irq, .rx_err_irq, .wake_req
   );
   // Slave held off during reset so start-up edges do not count
   spb_slave_mdl i_slv (
      .sck (sck_w), .mosi (mosi_w), .sel_n (!aresetn), .miso (s_miso), .rx_byte (s_rx), .n_bytes (s_n)
   );
   task automatic print_verdict;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic flag(input string nm, input logic e, input logic g);
      chk(nm, {7'h0, e}, {7'h0, g});
   endtask : flag
   // One bus access; seen at negedge, released after the taking edge
   task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
      logic ta, tw, tr, dn;
      @(posedge aclk);
      awaddr  <= a;
      araddr  <= a;
      wdata   <= {24'h0, d};
      awvalid <= w;
      wvalid  <= w;
      bready  <= w;
      arvalid <= !w;
      rready  <= !w;
      dn = 1'h0;
      for (int n = 0; n < 64 && !dn; n++) begin
         @(negedge aclk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tr = arvalid & arready;
         dn = (bvalid & bready) | (rvalid & rready);
         q  = rdata[7:0];
         rs = w ? bresp : rresp;
         @(posedge aclk);
         awvalid <= awvalid & !ta;
         wvalid  <= wvalid & !tw;
         arvalid <= arvalid & !tr;
         bready  <= bready & !dn;
         rready  <= rready & !dn;
      end
      @(negedge aclk);
      flag("bus_done", 1'h1, dn);
   endtask : acc
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      acc(1'h1, a, d);
      chk("bresp", {6'h0, SPB_RESP_OKAY}, {6'h0, rs});
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      acc(1'h0, a, 8'h0);
      chk("rdata", e, q);
   endtask : rd
   task automatic t_reset;
      rd(SPB_OFS_CTRL, 8'h28);
      rd(SPB_OFS_STAT, 8'h08);
      acc(1'h0, 4'hc, 8'h0);
      chk("rresp", {6'h0, SPB_RESP_SLVERR}, {6'h0, rs});
   endtask : t_reset
   // One byte, frozen in stop past its normal length
   task automatic t_xfer;
      wr(SPB_OFS_STAT, 8'h03);
      wr(SPB_OFS_CTRL, 8'hab);
      flag("tx_irq", 1'h1, tx_irq);
      wr(SPB_OFS_DATA, 8'ha5);
      @(posedge aclk);
      stp <= 1'h1;
      repeat (300) @(posedge aclk);
      stp <= 1'h0;
      chk("bytes", 8'h0, s_n[7:0]);
      repeat (600) if (!rx_err_irq) @(negedge aclk);
      flag("rx_irq", 1'h1, rx_err_irq);
      rd(SPB_OFS_STAT, 8'h8b);
      chk("slave_rx", 8'ha5, s_rx);
   endtask : t_xfer
   task automatic t_off;
      wr(SPB_OFS_CTRL, 8'ha9);
      flag("pins", 1'h0, pins_owned);
      flag("tx_irq", 1'h0, tx_irq);
      flag("rx_irq", 1'h1, rx_err_irq);
      rd(SPB_OFS_STAT, 8'h8b);
      wr(SPB_OFS_CTRL, 8'hab);
   endtask : t_off
   // Second byte lands on an unread one
   task automatic t_ovr;
      wr(SPB_OFS_DATA, 8'h5a);
      repeat (900) if (s_n < 2) @(negedge aclk);
      repeat (8) @(negedge aclk);
      @(posedge aclk);
      brk <= 1'h1;
      bce <= 1'h1;
      rd(SPB_OFS_STAT, 8'hab);
      rd(SPB_OFS_DATA, 8'h3c);
      @(posedge aclk);
      brk <= 1'h0;
      bce <= 1'h0;
      rd(SPB_OFS_STAT, 8'h0b);
      flag("rx_irq", 1'h0, rx_err_irq);
   endtask : t_ovr
   task automatic t_brk;
      @(posedge aclk);
      brk <= 1'h1;
      wr(SPB_OFS_DATA, 8'h11);
      repeat (300) @(negedge aclk);
      rd(SPB_OFS_STAT, 8'h0b);
      chk("bytes", 8'h2, s_n[7:0]);
      @(posedge aclk);
      brk <= 1'h0;
   endtask : t_brk
   task automatic t_wait;
      @(posedge aclk);
      wt <= 1'h1;
      acc(1'h0, SPB_OFS_CTRL, 8'h0);
      chk("rresp", {6'h0, SPB_RESP_SLVERR}, {6'h0, rs});
      flag("wake", 1'h1, wake_req);
      @(posedge aclk);
      wt <= 1'h0;
   endtask : t_wait
   // Select low in master mode, detect off then on
   task automatic t_fault;
      @(posedge aclk);
      ss_n <= 1'h0;
      rd(SPB_OFS_STAT, 8'h0b);
      @(posedge aclk);
      ss_n <= 1'h1;
      wr(SPB_OFS_STAT, 8'h47);
      @(posedge aclk);
      ss_n <= 1'h0;
      repeat (8) @(negedge aclk);
      rd(SPB_OFS_STAT, 8'h5f);
      rd(SPB_OFS_CTRL, 8'ha9);
      flag("rx_irq", 1'h1, rx_err_irq);
      @(posedge aclk);
      ss_n <= 1'h1;
      brk <= 1'h1;
      repeat (8) @(negedge aclk);
      wr(SPB_OFS_CTRL, 8'ha9);
      rd(SPB_OFS_STAT, 8'h5f);
      @(posedge aclk);
      brk <= 1'h0;
      wr(SPB_OFS_CTRL, 8'hab);
      rd(SPB_OFS_STAT, 8'h4f);
      wr(SPB_OFS_CTRL, 8'h8a);
      @(posedge aclk);
      ss_n <= 1'h0;
      repeat (8) @(negedge aclk);
      flag("miso", 1'h1, miso_oe);
      @(posedge aclk);
      ss_n <= 1'h1;
      repeat (8) @(negedge aclk);
      flag("miso", 1'h0, miso_oe);
   endtask : t_fault
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      t_reset();
      t_xfer();
      t_off();
      t_ovr();
      t_brk();
      t_wait();
      t_fault();
      print_verdict();
   end
   // Watchdog, far beyond the expected run
   initial begin
      #40000;
      failures++;
      print_verdict();
   end
endmodule : tb
